// ### design/csr_pkg.sv
// Shared constants of the chiller serial command register block
`default_nettype none
package csr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int FUNC_W = 8;
    localparam int SEL_W = 4;
    localparam int NUM_DISP = 4;

    // ------------------------------------------------------------
    // Register addresses (MODBUS register numbers)
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_DISP_BASE = 16'h0038;
    localparam logic [15:0] ADDR_SET_TEMP = 16'h0040;
    localparam logic [15:0] ADDR_RUN_CTRL = 16'h0041;
    localparam logic [15:0] ADDR_SRC_SEL = 16'h0043;

    // ------------------------------------------------------------
    // Function and exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
    localparam logic [7:0] READ_BYTE_COUNT = 8'h02;
    localparam logic [15:0] READ_QTY_ONE = 16'h0001;

    // ------------------------------------------------------------
    // Run control word fields
    // ------------------------------------------------------------
    localparam int RUN_BIT = 0;
    localparam int MODE_REQ_BIT = 1;
    localparam int ALM_RST_BIT = 2;
    localparam logic [15:0] RUN_CTRL_MASK = 16'h0007;

    // ------------------------------------------------------------
    // Display source selector codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_AMBIENT = 4'h1;
    localparam logic [3:0] SEL_EXT_TUNE = 4'h2;
    localparam logic [3:0] SEL_INLET = 4'h3;
    localparam logic [3:0] SEL_MAINT = 4'h4;
    localparam logic [3:0] SEL_PRESSURE = 4'h5;
    localparam logic [15:0] SRC_SEL_RESET = 16'h0000;
    localparam logic [15:0] RUN_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

endpackage : csr_pkg
`default_nettype wire

// ### design/csr_sel_mux.sv
// One data display: registered selection of a source by a 4-bit code
`timescale 1ns/1ps
`default_nettype none

module csr_sel_mux (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [csr_pkg::SEL_W-1:0] sel_i,
    input wire logic [csr_pkg::WORD_W-1:0] ambient_i,
    input wire logic [csr_pkg::WORD_W-1:0] ext_tune_i,
    input wire logic [csr_pkg::WORD_W-1:0] inlet_i,
    input wire logic [csr_pkg::WORD_W-1:0] maint_i,
    input wire logic [csr_pkg::WORD_W-1:0] pressure_i,
    output logic [csr_pkg::WORD_W-1:0] data_o
);
    import csr_pkg::*;

    logic [WORD_W-1:0] data_next;

    // Pick the source; codes 0 and 6..15 fall through to zero
    always_comb begin
        case (sel_i)
            SEL_AMBIENT: data_next = ambient_i;
            SEL_EXT_TUNE: data_next = ext_tune_i;
            SEL_INLET: data_next = inlet_i;
            SEL_MAINT: data_next = maint_i;
            SEL_PRESSURE: data_next = pressure_i;
            default: data_next = ZERO_WORD;
        endcase
    end

    // Refreshed every cycle, so a new selector shows one edge later
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            data_o <= ZERO_WORD;
        end else begin
            data_o <= data_next;
        end
    end

endmodule : csr_sel_mux
`default_nettype wire

// ### design/csr_regs.sv
// Command and display registers of the chiller serial slave
//
// Operation
// - Over-range set temperature stores the upper limit
// - Under-range set temperature stores the lower limit
// - Set temperature written only in serial mode
// - Run bit 0: 1 starts, 0 stops
// - Run bit obeyed in serial, contact off
// - Mode bit rising enters serial, falling keeps
// - Alarm reset on bit 2 rising only, in serial mode
// - Four 4-bit selectors, one per display
// - Selector codes 1 to 5 pick sources, 0 shows zero
// - Each display follows its own selector
// - Selection word write at 0x0043, echoed
// - Write frame fields, big-endian, framer builds bytes
// - Display 1 at 0x0038, read answers two bytes
// - Temperatures signed, tenth degree per count
`timescale 1ns/1ps
`default_nettype none

module csr_regs #(
    parameter logic signed [15:0] TEMP_MIN = 16'sh0032,
    parameter logic signed [15:0] TEMP_MAX = 16'sh0190,
    parameter logic [15:0] SET_TEMP_RESET = 16'h00C8
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // Decoded request from the frame engine
    input wire logic REQ_VALID_I,
    input wire logic [csr_pkg::FUNC_W-1:0] REQ_FUNC_I,
    input wire logic [csr_pkg::WORD_W-1:0] REQ_ADDR_I,
    input wire logic [csr_pkg::WORD_W-1:0] REQ_DATA_I,
    // Answer to the frame engine
    output logic RSP_VALID_O,
    output logic [csr_pkg::FUNC_W-1:0] RSP_FUNC_O,
    output logic [csr_pkg::WORD_W-1:0] RSP_ADDR_O,
    output logic [csr_pkg::FUNC_W-1:0] RSP_COUNT_O,
    output logic [csr_pkg::WORD_W-1:0] RSP_DATA_O,
    // Plant side
    input wire logic CONTACT_INPUT_RUN_STOP_SETTING_I,
    input wire logic SERIAL_MODE_EXIT_I,
    input wire logic [csr_pkg::WORD_W-1:0] AMBIENT_TEMP_I,
    input wire logic [csr_pkg::WORD_W-1:0] EXT_TUNE_TEMP_I,
    input wire logic [csr_pkg::WORD_W-1:0] INLET_TEMP_I,
    input wire logic [csr_pkg::WORD_W-1:0] MAINT_NOTICE_I,
    input wire logic [csr_pkg::WORD_W-1:0] REFRIG_PRESSURE_I,
    output logic SERIAL_MODE_O,
    output logic RUN_O,
    output logic ALARM_RESET_O,
    output logic [csr_pkg::WORD_W-1:0] SET_TEMP_O
);
    import csr_pkg::*;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic is_write;
    logic is_read;
    logic wr_set_temp;
    logic wr_run_ctrl;
    logic wr_src_sel;
    logic disp_hit;
    logic [1:0] disp_idx;
    logic [WORD_W-1:0] disp_off;
    logic rising_mode;
    logic rising_alarm;
    logic signed [WORD_W-1:0] temp_wr;
    logic [WORD_W-1:0] temp_clamped;

    logic serial_mode_reg;
    logic run_reg;
    logic alarm_reset_reg;
    logic [WORD_W-1:0] set_temp_reg;
    logic [WORD_W-1:0] run_ctrl_reg;
    logic [WORD_W-1:0] src_sel_reg;
    logic [WORD_W-1:0] disp_data [NUM_DISP];

    // Only one function code is legal per access kind: 06 writes, 04 reads
    assign is_write = REQ_VALID_I && (REQ_FUNC_I == FC_WRITE_SINGLE);
    assign is_read = REQ_VALID_I && (REQ_FUNC_I == FC_READ_INPUT);
    assign wr_set_temp = is_write && (REQ_ADDR_I == ADDR_SET_TEMP);
    assign wr_run_ctrl = is_write && (REQ_ADDR_I == ADDR_RUN_CTRL);
    assign wr_src_sel = is_write && (REQ_ADDR_I == ADDR_SRC_SEL);
    assign disp_off = REQ_ADDR_I - ADDR_DISP_BASE;
    assign disp_hit = (REQ_ADDR_I >= ADDR_DISP_BASE) &&
                      (disp_off < WORD_W'(NUM_DISP));
    assign disp_idx = disp_off[1:0];

    // Edges are judged against the last written word, not the
    // live level, so a bit rewritten at 1 fires nothing
    assign rising_mode = REQ_DATA_I[MODE_REQ_BIT] &&
                         !run_ctrl_reg[MODE_REQ_BIT];
    assign rising_alarm = REQ_DATA_I[ALM_RST_BIT] &&
                          !run_ctrl_reg[ALM_RST_BIT];

    // Signed limit check on the written temperature
    assign temp_wr = REQ_DATA_I;
    always_comb begin
        if (temp_wr > TEMP_MAX) begin
            temp_clamped = TEMP_MAX;
        end else if (temp_wr < TEMP_MIN) begin
            temp_clamped = TEMP_MIN;
        end else begin
            temp_clamped = temp_wr;
        end
    end

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------

    // Serial mode: entered by the mode bit, left only from the panel
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            serial_mode_reg <= 1'b0;
        end else if (wr_run_ctrl && rising_mode) begin
            serial_mode_reg <= 1'b1;
        end else if (SERIAL_MODE_EXIT_I) begin
            serial_mode_reg <= 1'b0;
        end
    end

    // Last written run word; unused bits never stored
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            run_ctrl_reg <= RUN_CTRL_RESET;
        end else if (wr_run_ctrl) begin
            run_ctrl_reg <= REQ_DATA_I & RUN_CTRL_MASK;
        end
    end

    // Run command; mode granted by this same write does not yet count
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            run_reg <= 1'b0;
        end else if (wr_run_ctrl && serial_mode_reg &&
                     !CONTACT_INPUT_RUN_STOP_SETTING_I) begin
            run_reg <= REQ_DATA_I[RUN_BIT];
        end
    end

    // One-cycle alarm reset strobe
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            alarm_reset_reg <= 1'b0;
        end else begin
            alarm_reset_reg <= wr_run_ctrl && serial_mode_reg &&
                               rising_alarm;
        end
    end

    // Set temperature, clamped into range
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            set_temp_reg <= SET_TEMP_RESET;
        end else if (wr_set_temp && serial_mode_reg) begin
            set_temp_reg <= temp_clamped;
        end
    end

    // Display source selection word
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            src_sel_reg <= SRC_SEL_RESET;
        end else if (wr_src_sel) begin
            src_sel_reg <= REQ_DATA_I;
        end
    end

    // ------------------------------------------------------------
    // Data displays, one registered selector each
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_DISP; g++) begin : g_disp
        csr_sel_mux u_mux (
            .sys_clk_i(SYS_CLK_I),
            .rst_n_i(RST_N_I),
            .sel_i(src_sel_reg[g*SEL_W +: SEL_W]),
            .ambient_i(AMBIENT_TEMP_I),
            .ext_tune_i(EXT_TUNE_TEMP_I),
            .inlet_i(INLET_TEMP_I),
            .maint_i(MAINT_NOTICE_I),
            .pressure_i(REFRIG_PRESSURE_I),
            .data_o(disp_data[g])
        );
    end

    // ------------------------------------------------------------
    // Response builder
    // ------------------------------------------------------------
    logic [FUNC_W-1:0] rsp_func_next;
    logic [FUNC_W-1:0] rsp_count_next;
    logic [WORD_W-1:0] rsp_data_next;
    logic rd_hit;
    logic [WORD_W-1:0] rd_word;
    logic [FUNC_W-1:0] exc_code;

    // Read mux; register values seen before this request's write
    always_comb begin
        rd_hit = 1'b1;
        rd_word = ZERO_WORD;
        if (disp_hit) begin
            rd_word = disp_data[disp_idx];
        end else if (REQ_ADDR_I == ADDR_SET_TEMP) begin
            rd_word = set_temp_reg;
        end else if (REQ_ADDR_I == ADDR_RUN_CTRL) begin
            rd_word = run_ctrl_reg;
        end else if (REQ_ADDR_I == ADDR_SRC_SEL) begin
            rd_word = src_sel_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Exception code, zero when the request is good
    always_comb begin
        if (!is_write && !is_read) begin
            exc_code = EXC_ILL_FUNC;
        end else if (is_write && !(wr_set_temp || wr_run_ctrl ||
                                   wr_src_sel)) begin
            exc_code = EXC_ILL_ADDR;
        end else if (is_read && !rd_hit) begin
            exc_code = EXC_ILL_ADDR;
        end else if (is_read && REQ_DATA_I != READ_QTY_ONE) begin
            exc_code = EXC_ILL_VALUE;
        end else begin
            exc_code = 8'h00;
        end
    end

    // Good write echoes value; good read gives count 2 and word
    always_comb begin
        if (exc_code != 8'h00) begin
            rsp_func_next = REQ_FUNC_I | FC_EXC_FLAG;
            rsp_count_next = 8'h00;
            rsp_data_next = {8'h00, exc_code};
        end else if (is_read) begin
            rsp_func_next = REQ_FUNC_I;
            rsp_count_next = READ_BYTE_COUNT;
            rsp_data_next = rd_word;
        end else begin
            rsp_func_next = REQ_FUNC_I;
            rsp_count_next = 8'h00;
            rsp_data_next = REQ_DATA_I;
        end
    end

    // Answer registered one edge after the request
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            RSP_VALID_O <= 1'b0;
            RSP_FUNC_O <= 8'h00;
            RSP_ADDR_O <= ZERO_WORD;
            RSP_COUNT_O <= 8'h00;
            RSP_DATA_O <= ZERO_WORD;
        end else begin
            RSP_VALID_O <= REQ_VALID_I;
            if (REQ_VALID_I) begin
                RSP_FUNC_O <= rsp_func_next;
                RSP_ADDR_O <= REQ_ADDR_I;
                RSP_COUNT_O <= rsp_count_next;
                RSP_DATA_O <= rsp_data_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Plant outputs
    // ------------------------------------------------------------
    assign SERIAL_MODE_O = serial_mode_reg;
    assign RUN_O = run_reg;
    assign ALARM_RESET_O = alarm_reset_reg;
    assign SET_TEMP_O = set_temp_reg;

endmodule : csr_regs
`default_nettype wire

// ### tb/csr_host_model.sv
// Host model issuing single-word MODBUS requests to the register block
`timescale 1ns/1ps
`default_nettype none

module csr_host_model (
    input wire logic clk_i,
    output logic vld_o,
    output logic [7:0] func_o,
    output logic [15:0] addr_o,
    output logic [15:0] data_o
);
    // Quiet bus at time zero
    initial begin
        vld_o = 1'b0;
        func_o = 8'h00;
        addr_o = 16'h0000;
        data_o = 16'h0000;
    end

    // Hold a request over its taking edge; afterwards scramble the lines
    // so a stale request can never pass for a live one
    task automatic send(input logic [7:0] f, input logic [15:0] a,
                        input logic [15:0] d);
        @(posedge clk_i);
        vld_o <= 1'b1;
        func_o <= f;
        addr_o <= a;
        data_o <= d;
        @(posedge clk_i);
        vld_o <= 1'b0;
        func_o <= ~f;
        addr_o <= ~a;
        data_o <= ~d;
        #1;
    endtask : send
endmodule : csr_host_model

`default_nettype wire

// ### tb/csr_regs_asserts.sv
// Concurrent checks on the ports of the command register block
`timescale 1ns/1ps
`default_nettype none

module csr_regs_asserts #(
    parameter logic signed [15:0] TEMP_MIN = 16'sh0032,
    parameter logic signed [15:0] TEMP_MAX = 16'sh0190
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic REQ_VALID_I,
    input wire logic [csr_pkg::FUNC_W-1:0] REQ_FUNC_I,
    input wire logic [csr_pkg::WORD_W-1:0] REQ_ADDR_I,
    input wire logic [csr_pkg::WORD_W-1:0] REQ_DATA_I,
    input wire logic RSP_VALID_O,
    input wire logic [csr_pkg::FUNC_W-1:0] RSP_FUNC_O,
    input wire logic [csr_pkg::WORD_W-1:0] RSP_ADDR_O,
    input wire logic [csr_pkg::WORD_W-1:0] RSP_DATA_O,
    input wire logic CONTACT_INPUT_RUN_STOP_SETTING_I,
    input wire logic SERIAL_MODE_EXIT_I,
    input wire logic SERIAL_MODE_O,
    input wire logic RUN_O,
    input wire logic ALARM_RESET_O,
    input wire logic [csr_pkg::WORD_W-1:0] SET_TEMP_O
);
    import csr_pkg::*;
    logic alm_cause;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    // ------------------------------------------------------------
    // Request shapes
    // ------------------------------------------------------------
    sequence s_wr(a);
        REQ_VALID_I && REQ_FUNC_I == FC_WRITE_SINGLE && REQ_ADDR_I == a;
    endsequence
    sequence s_rd_run;
        REQ_VALID_I && REQ_FUNC_I == FC_READ_INPUT &&
        REQ_ADDR_I == ADDR_RUN_CTRL && REQ_DATA_I == READ_QTY_ONE;
    endsequence
    // Only a serial-mode run word write with bit 2 set may pulse reset
    assign alm_cause = REQ_VALID_I && REQ_FUNC_I == FC_WRITE_SINGLE &&
        REQ_ADDR_I == ADDR_RUN_CTRL && REQ_DATA_I[ALM_RST_BIT] &&
        SERIAL_MODE_O;

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_answer;
        RSP_VALID_O == $past(REQ_VALID_I);
    endproperty
    a_answer: assert property (p_answer)
        else $error("answer strobe not one cycle after request");
    property p_echo;
        s_wr(ADDR_SRC_SEL) |=> RSP_FUNC_O == FC_WRITE_SINGLE &&
            RSP_ADDR_O == ADDR_SRC_SEL && RSP_DATA_O == $past(REQ_DATA_I);
    endproperty
    a_echo: assert property (p_echo)
        else $error("selection write not echoed");
    property p_clamp_hi;
        s_wr(ADDR_SET_TEMP) ##0 (SERIAL_MODE_O &&
            $signed(REQ_DATA_I) > TEMP_MAX) |=> SET_TEMP_O == TEMP_MAX;
    endproperty
    a_clamp_hi: assert property (p_clamp_hi)
        else $error("high set temperature not clamped");
    property p_clamp_lo;
        s_wr(ADDR_SET_TEMP) ##0 (SERIAL_MODE_O &&
            $signed(REQ_DATA_I) < TEMP_MIN) |=> SET_TEMP_O == TEMP_MIN;
    endproperty
    a_clamp_lo: assert property (p_clamp_lo)
        else $error("low set temperature not clamped");
    property p_set_locked;
        s_wr(ADDR_SET_TEMP) ##0 !SERIAL_MODE_O |=> $stable(SET_TEMP_O);
    endproperty
    a_set_locked: assert property (p_set_locked)
        else $error("set temperature changed outside serial mode");
    property p_run;
        s_wr(ADDR_RUN_CTRL) ##0 (SERIAL_MODE_O && !SERIAL_MODE_EXIT_I &&
            !CONTACT_INPUT_RUN_STOP_SETTING_I)
            |=> RUN_O == $past(REQ_DATA_I[RUN_BIT]);
    endproperty
    a_run: assert property (p_run)
        else $error("run output does not follow bit 0");
    property p_contact;
        CONTACT_INPUT_RUN_STOP_SETTING_I |=> $stable(RUN_O);
    endproperty
    a_contact: assert property (p_contact)
        else $error("run changed while contact setting on");
    property p_mode_keep;
        SERIAL_MODE_O && !SERIAL_MODE_EXIT_I |=> SERIAL_MODE_O;
    endproperty
    a_mode_keep: assert property (p_mode_keep)
        else $error("serial mode dropped without exit");
    property p_alarm;
        ALARM_RESET_O |-> $past(alm_cause) ##1 !ALARM_RESET_O;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm reset pulse without cause");
    property p_run_rd;
        s_rd_run |=> RSP_DATA_O[15:3] == 13'h0000;
    endproperty
    a_run_rd: assert property (p_run_rd)
        else $error("unused run word bits read nonzero");
endmodule : csr_regs_asserts

bind csr_regs csr_regs_asserts #(
    .TEMP_MIN(TEMP_MIN),
    .TEMP_MAX(TEMP_MAX)
) u_chk (
    .SYS_CLK_I(SYS_CLK_I),
    .RST_N_I(RST_N_I),
    .REQ_VALID_I(REQ_VALID_I),
    .REQ_FUNC_I(REQ_FUNC_I),
    .REQ_ADDR_I(REQ_ADDR_I),
    .REQ_DATA_I(REQ_DATA_I),
    .RSP_VALID_O(RSP_VALID_O),
    .RSP_FUNC_O(RSP_FUNC_O),
    .RSP_ADDR_O(RSP_ADDR_O),
    .RSP_DATA_O(RSP_DATA_O),
    .CONTACT_INPUT_RUN_STOP_SETTING_I(CONTACT_INPUT_RUN_STOP_SETTING_I),
    .SERIAL_MODE_EXIT_I(SERIAL_MODE_EXIT_I),
    .SERIAL_MODE_O(SERIAL_MODE_O),
    .RUN_O(RUN_O),
    .ALARM_RESET_O(ALARM_RESET_O),
    .SET_TEMP_O(SET_TEMP_O)
);

`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the chiller serial command registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import csr_pkg::*;
    typedef struct packed {
        logic [7:0] f;
        logic [15:0] a;
        logic [15:0] d;
        logic [7:0] ef;
        logic [7:0] ec;
        logic [15:0] ed;
    } csr_row_t;
    logic SYS_CLK_I, RST_N_I, REQ_VALID_I, RSP_VALID_O;
    logic [7:0] REQ_FUNC_I, RSP_FUNC_O, RSP_COUNT_O;
    logic [15:0] REQ_ADDR_I, REQ_DATA_I, RSP_ADDR_O, RSP_DATA_O, SET_TEMP_O;
    logic CONTACT_INPUT_RUN_STOP_SETTING_I, SERIAL_MODE_EXIT_I;
    logic SERIAL_MODE_O, RUN_O, ALARM_RESET_O;
    logic [15:0] AMBIENT_TEMP_I, EXT_TUNE_TEMP_I, INLET_TEMP_I;
    logic [15:0] MAINT_NOTICE_I, REFRIG_PRESSURE_I, w;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // Request, expected function, byte count and data word
    csr_row_t rows [12] = '{
        '{8'h06, 16'h0043, 16'h0001, 8'h06, 8'h00, 16'h0001},
        '{8'h06, 16'h0041, 16'h0002, 8'h06, 8'h00, 16'h0002},
        '{8'h06, 16'h0040, 16'h0200, 8'h06, 8'h00, 16'h0200},
        '{8'h04, 16'h0040, 16'h0001, 8'h04, 8'h02, 16'h0190},
        '{8'h06, 16'h0040, 16'hFFF0, 8'h06, 8'h00, 16'hFFF0},
        '{8'h04, 16'h0040, 16'h0001, 8'h04, 8'h02, 16'h0032},
        '{8'h06, 16'h0041, 16'hFFFA, 8'h06, 8'h00, 16'hFFFA},
        '{8'h04, 16'h0041, 16'h0001, 8'h04, 8'h02, 16'h0002},
        '{8'h04, 16'h0038, 16'h0001, 8'h04, 8'h02, 16'h00FA},
        '{8'h06, 16'h0050, 16'h0001, 8'h86, 8'h00, 16'h0002},
        '{8'h03, 16'h0038, 16'h0001, 8'h83, 8'h00, 16'h0001},
        '{8'h04, 16'h0038, 16'h0002, 8'h84, 8'h00, 16'h0003}
    };

    csr_regs DUT (
        .SYS_CLK_I(SYS_CLK_I),
        .RST_N_I(RST_N_I),
        .REQ_VALID_I(REQ_VALID_I),
        .REQ_FUNC_I(REQ_FUNC_I),
        .REQ_ADDR_I(REQ_ADDR_I),
        .REQ_DATA_I(REQ_DATA_I),
        .RSP_VALID_O(RSP_VALID_O),
        .RSP_FUNC_O(RSP_FUNC_O),
        .RSP_ADDR_O(RSP_ADDR_O),
        .RSP_COUNT_O(RSP_COUNT_O),
        .RSP_DATA_O(RSP_DATA_O),
        .CONTACT_INPUT_RUN_STOP_SETTING_I(CONTACT_INPUT_RUN_STOP_SETTING_I),
        .SERIAL_MODE_EXIT_I(SERIAL_MODE_EXIT_I),
        .AMBIENT_TEMP_I(AMBIENT_TEMP_I),
        .EXT_TUNE_TEMP_I(EXT_TUNE_TEMP_I),
        .INLET_TEMP_I(INLET_TEMP_I),
        .MAINT_NOTICE_I(MAINT_NOTICE_I),
        .REFRIG_PRESSURE_I(REFRIG_PRESSURE_I),
        .SERIAL_MODE_O(SERIAL_MODE_O),
        .RUN_O(RUN_O),
        .ALARM_RESET_O(ALARM_RESET_O),
        .SET_TEMP_O(SET_TEMP_O)
    );
    csr_host_model HOST (
        .clk_i(SYS_CLK_I),
        .vld_o(REQ_VALID_I),
        .func_o(REQ_FUNC_I),
        .addr_o(REQ_ADDR_I),
        .data_o(REQ_DATA_I)
    );

    // 250 MHz clock
    initial begin
        SYS_CLK_I = 1'b0;
        forever #2 SYS_CLK_I = ~SYS_CLK_I;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic io(input csr_row_t r);
        HOST.send(r.f, r.a, r.d);
        chk({15'h0000, RSP_VALID_O}, 16'h0001);
        chk({RSP_FUNC_O, RSP_COUNT_O}, {r.ef, r.ec});
        chk(RSP_DATA_O, r.ed);
        chk(RSP_ADDR_O, r.a);
    endtask : io
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        io(csr_row_t'{8'h06, a, d, 8'h06, 8'h00, d});
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        io(csr_row_t'{8'h04, a, 16'h0001, 8'h04, 8'h02, e});
    endtask : rd
    // Distinct word per source; codes outside 1 to 5 show zero
    function automatic logic [15:0] srcv(int j, int k);
        return (j >= 1 && j <= 5) ? 16'(4096 * j + k) : 16'h0000;
    endfunction : srcv
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // Hang guard: the whole run needs about 140 cycles
    always @(posedge SYS_CLK_I) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            $display("ERROR %0t: timeout", $time);
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        RST_N_I = 1'b0;
        CONTACT_INPUT_RUN_STOP_SETTING_I = 1'b0;
        SERIAL_MODE_EXIT_I = 1'b0;
        AMBIENT_TEMP_I = 16'h00FA;
        EXT_TUNE_TEMP_I = 16'hF334;
        INLET_TEMP_I = 16'h0100;
        MAINT_NOTICE_I = 16'h0005;
        REFRIG_PRESSURE_I = 16'h0123;
        repeat (2) @(posedge SYS_CLK_I);
        RST_N_I <= 1'b1;
        foreach (rows[i]) begin
            io(rows[i]);
        end
        $display("test rows done");
        for (int k = 0; k < 8; k++) begin
            @(posedge SYS_CLK_I);
            AMBIENT_TEMP_I <= srcv(1, k);
            EXT_TUNE_TEMP_I <= srcv(2, k);
            INLET_TEMP_I <= srcv(3, k);
            MAINT_NOTICE_I <= srcv(4, k);
            REFRIG_PRESSURE_I <= srcv(5, k);
            w = {4'((k + 3) % 8), 4'((k + 2) % 8), 4'((k + 1) % 8), 4'(k)};
            wr(16'h0043, w);
            for (int i = 0; i < 4; i++) begin
                rd(16'h0038 + 16'(i), srcv((k+i)%8, k));
            end
        end
        $display("test selectors done");
        wr(16'h0041, 16'h0007);
        chk({14'h0000, RUN_O, ALARM_RESET_O}, 16'h0003);
        wr(16'h0041, 16'h0007);
        chk({15'h0000, ALARM_RESET_O}, 16'h0000);
        wr(16'h0041, 16'h0000);
        chk({14'h0000, RUN_O, SERIAL_MODE_O}, 16'h0001);
        @(posedge SYS_CLK_I);
        CONTACT_INPUT_RUN_STOP_SETTING_I <= 1'b1;
        wr(16'h0041, 16'h0001);
        chk({15'h0000, RUN_O}, 16'h0000);
        @(posedge SYS_CLK_I);
        CONTACT_INPUT_RUN_STOP_SETTING_I <= 1'b0;
        SERIAL_MODE_EXIT_I <= 1'b1;
        @(posedge SYS_CLK_I);
        SERIAL_MODE_EXIT_I <= 1'b0;
        wr(16'h0040, 16'h0100);
        rd(16'h0040, 16'h0032);
        wr(16'h0041, 16'h0001);
        chk({14'h0000, RUN_O, SERIAL_MODE_O}, 16'h0000);
        $display("test run and mode done");
        @(posedge SYS_CLK_I);
        RST_N_I <= 1'b0;
        repeat (2) @(posedge SYS_CLK_I);
        RST_N_I <= 1'b1;
        #1;
        chk(SET_TEMP_O, 16'h00C8);
        chk({14'h0000, RUN_O, SERIAL_MODE_O}, 16'h0000);
        rd(16'h0043, 16'h0000);
        $display("test reset done");
        conclude();
    end
endmodule : testbench

`default_nettype wire
